// ---- design/sar_adc_pkg.sv ----
// Purpose: constants and carrier types for the SAR converter control
// Assumes: 20 MHz system clock, no register bus, fields on plain ports
// Notes:   each number lives here once; logic uses the names
`default_nettype none
package sar_adc_pkg;

	// ----------------------------------------------------------------
	// result and conversion length
	// ----------------------------------------------------------------
	localparam int         RES_BITS           = 10;
	localparam logic [4:0] HALF_TAD_ZERO      = 5'h00;
	localparam logic [4:0] HALF_TAD_ONE       = 5'h01;
	localparam logic [4:0] HALF_TAD_FIRST_BIT = 5'h03; // first bit decision
	localparam logic [4:0] HALF_TAD_LAST      = 5'h16; // 23 halves, 11.5 tad
	localparam logic [9:0] SAR_MSB            = 10'h200;
	localparam logic [9:0] SAR_ZERO           = 10'h000;
	localparam logic [5:0] FMT_PAD            = 6'h00; // unused result bits

	// ----------------------------------------------------------------
	// conversion clock select codes and half periods in system clocks
	// ----------------------------------------------------------------
	localparam logic [2:0] CCS_DIV2   = 3'h0;
	localparam logic [2:0] CCS_DIV4   = 3'h4;
	localparam logic [2:0] CCS_DIV8   = 3'h1;
	localparam logic [2:0] CCS_DIV16  = 3'h5;
	localparam logic [2:0] CCS_DIV32  = 3'h2;
	localparam logic [2:0] CCS_DIV64  = 3'h6;
	localparam logic [1:0] CCS_RC_LOW = 2'h3;  // any x11 code
	localparam logic [5:0] HALF_DIV2  = 6'h01;
	localparam logic [5:0] HALF_DIV4  = 6'h02;
	localparam logic [5:0] HALF_DIV8  = 6'h04;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV32 = 6'h10;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [5:0] DIV_ZERO   = 6'h00;
	localparam logic [5:0] DIV_ONE    = 6'h01;

	// ----------------------------------------------------------------
	// reference select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] PREF_PIN  = 2'h0;   // external positive pin
	localparam logic [1:0] PREF_VDD  = 2'h1;   // supply
	localparam logic [1:0] PREF_FVR2 = 2'h2;   // fixed_reference 2.048 V
	localparam logic [1:0] PREF_FVR4 = 2'h3;   // fixed_reference 4.096 V
	localparam logic       NREF_GND  = 1'b0;   // ground
	localparam logic       NREF_PIN  = 1'b1;   // external negative pin

	// ----------------------------------------------------------------
	// states and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} conv_state_t;

	typedef struct packed {
		logic [5:0] channel_select;    // mux input
		logic [1:0] pos_ref_select;    // positive reference
		logic       neg_ref_select;    // negative reference
		logic [2:0] conv_clock_select; // conversion clock
		logic       result_format;     // 1 left, 0 right
	} conv_cfg_t;

	typedef struct packed {
		logic [5:0] mux_channel;       // channel routed to the hold stage
		logic [1:0] pos_ref;           // positive reference steering
		logic       neg_ref;           // negative reference steering
		logic [9:0] trial_code;        // dac trial code for comparator
		logic       hold;              // 1 holds the sampled input
	} analog_ctrl_t;

	localparam analog_ctrl_t ANA_RESET = '0;

endpackage
`default_nettype wire

// ---- design/sar_adc_control.sv ----
// Purpose: control of a 10-bit successive approximation converter
// Assumes: one 20 MHz clock; dedicated rc clock and trigger are async pins
// Notes:   comparator input cmp_keep is same-clock analog decision logic
`timescale 1ns/10ps
`default_nettype none

module sar_adc_control #(
	parameter bit LOW_VOLTAGE_PART = 1'b0 // removes the 4.096 V reference
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire sar_adc_pkg::conv_cfg_t    cfg,
	input  wire logic                      converter_on,
	input  wire logic                      go_set,
	input  wire logic                      flag_clear,
	input  wire logic                      conv_irq_enable,
	input  wire logic                      peripheral_irq_enable,
	input  wire logic                      global_irq_enable,
	input  wire logic                      sleep_mode,
	input  wire logic                      rc_clock_pin,
	input  wire logic                      trigger_pin,
	input  wire logic                      cmp_keep,
	output var  sar_adc_pkg::analog_ctrl_t analog_ctrl,
	output logic [7:0]                     result_high,
	output logic [7:0]                     result_low,
	output logic                           conv_go,
	output logic                           conv_done_flag,
	output logic                           converter_active,
	output logic                           wake_req,
	output logic                           vector_isr
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// rc clock selected by any x11 code
	function automatic logic is_rc(input logic [2:0] code);
		return code[1:0] == sar_adc_pkg::CCS_RC_LOW;
	endfunction

	// half a bit period, in system clocks, for a divided clock
	function automatic logic [5:0] half_count(input logic [2:0] code);
		logic [5:0] h;
		h = sar_adc_pkg::HALF_DIV2;
		case (code)
			sar_adc_pkg::CCS_DIV4:  h = sar_adc_pkg::HALF_DIV4;
			sar_adc_pkg::CCS_DIV8:  h = sar_adc_pkg::HALF_DIV8;
			sar_adc_pkg::CCS_DIV16: h = sar_adc_pkg::HALF_DIV16;
			sar_adc_pkg::CCS_DIV32: h = sar_adc_pkg::HALF_DIV32;
			sar_adc_pkg::CCS_DIV64: h = sar_adc_pkg::HALF_DIV64;
			default:                h = sar_adc_pkg::HALF_DIV2;
		endcase
		return h;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] rc_sync_q;   // [0] first stage, [2] edge history
	logic [2:0] rc_sync_d;
	logic [2:0] trig_sync_q; // same layout for the trigger pin
	logic [2:0] trig_sync_d;
	logic       rc_edge;     // either rc edge: half a bit period
	logic       trig_rise;   // trigger rising edge

	// shift pins in; only stage two and three are examined
	always_comb begin
		rc_sync_d   = {rc_sync_q[1:0], rc_clock_pin};
		trig_sync_d = {trig_sync_q[1:0], trigger_pin};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rc_sync_q   <= 3'h0;
			trig_sync_q <= 3'h0;
		end else begin
			rc_sync_q   <= rc_sync_d;
			trig_sync_q <= trig_sync_d;
		end
	end

	assign rc_edge   = rc_sync_q[1] ^ rc_sync_q[2];
	assign trig_rise = trig_sync_q[1] & ~trig_sync_q[2];

	// ----------------------------------------------------------------
	// conversion state
	// ----------------------------------------------------------------
	sar_adc_pkg::conv_state_t  state_q, state_d;  // idle or converting
	logic [4:0]                half_q, half_d;    // half bit periods
	logic [5:0]                div_q, div_d;      // system clock divider
	logic [9:0]                sar_q, sar_d;      // trial code
	logic [9:0]                bit_q, bit_d;      // bit under test
	logic                      go_q, go_d;        // conversion request
	logic                      flag_q, flag_d;    // sticky done flag
	logic [7:0]                hi_q, hi_d;        // result_high
	logic [7:0]                lo_q, lo_d;        // result_low
	logic                      wake_q, wake_d;    // wake pulse
	logic                      vec_q, vec_d;      // vector pulse
	sar_adc_pkg::analog_ctrl_t ana_q, ana_d;      // analog steering
	logic                      run_ok;            // converter may run
	logic                      half_tick;         // half bit period edge
	logic                      done;              // completion this cycle
	logic                      go_req;            // software or trigger

	// only the rc clock keeps running through sleep
	assign run_ok = converter_on &
		(~sleep_mode | is_rc(cfg.conv_clock_select));

	// divided clocks count system clocks, so they follow its rate
	assign half_tick = is_rc(cfg.conv_clock_select) ? rc_edge :
		(div_q == half_count(cfg.conv_clock_select) -
		sar_adc_pkg::DIV_ONE);

	// software start or trigger edge; trigger is dead in sleep
	assign go_req = converter_on &
		(go_set | (trig_rise & ~sleep_mode));

	// next-state logic for the whole conversion
	always_comb begin
		state_d = state_q;
		half_d  = half_q;
		div_d   = div_q;
		sar_d   = sar_q;
		bit_d   = bit_q;
		go_d    = go_q;
		flag_d  = flag_q;
		hi_d    = hi_q;
		lo_d    = lo_q;
		wake_d  = 1'b0;
		vec_d   = 1'b0;
		done    = 1'b0;
		// software clear first so a same-cycle completion wins
		if (flag_clear) begin
			flag_d = 1'b0;
		end
		unique case (state_q)
			// waiting: keep the divider aligned for the next start
			sar_adc_pkg::ST_IDLE: begin
				div_d  = sar_adc_pkg::DIV_ZERO;
				half_d = sar_adc_pkg::HALF_TAD_ZERO;
				if (go_q && run_ok) begin
					state_d = sar_adc_pkg::ST_CONV;
					sar_d   = sar_adc_pkg::SAR_MSB;
					bit_d   = sar_adc_pkg::SAR_MSB;
				end else if (go_q) begin
					go_d = 1'b0;
				end
			end
			// converting: one bit decided per bit period
			sar_adc_pkg::ST_CONV: begin
				if (!run_ok) begin
					state_d = sar_adc_pkg::ST_IDLE;
					go_d    = 1'b0;
				end else if (!half_tick) begin
					div_d = div_q + sar_adc_pkg::DIV_ONE;
				end else begin
					div_d  = sar_adc_pkg::DIV_ZERO;
					half_d = half_q + sar_adc_pkg::HALF_TAD_ONE;
					if (half_q == sar_adc_pkg::HALF_TAD_LAST) begin
						// completion after 23 half periods
						done    = 1'b1;
						state_d = sar_adc_pkg::ST_IDLE;
						go_d    = 1'b0;
						flag_d  = 1'b1;
						if (cfg.result_format) begin
							// left: top ten bits of the pair
							hi_d = sar_q[9:2];
							lo_d = {sar_q[1:0], sar_adc_pkg::FMT_PAD};
						end else begin
							// right: bottom ten bits of the pair
							hi_d = {sar_adc_pkg::FMT_PAD, sar_q[9:8]};
							lo_d = sar_q[7:0];
						end
						wake_d = sleep_mode & conv_irq_enable &
							peripheral_irq_enable;
						vec_d = sleep_mode & conv_irq_enable &
							peripheral_irq_enable &
							global_irq_enable;
					end else if (half_q[0] &&
						half_q >= sar_adc_pkg::HALF_TAD_FIRST_BIT) begin
						// keep or drop the tested bit, try the next
						if (!cmp_keep) begin
							sar_d = sar_q & ~bit_q;
						end
						bit_d = bit_q >> 1;
						sar_d = sar_d | (bit_q >> 1);
					end
				end
			end
		endcase
		// a new start request outranks the clear at completion
		if (go_req) begin
			go_d = 1'b1;
		end
	end

	// analog steering: mux, references, trial code, hold
	always_comb begin
		ana_d             = ana_q;
		ana_d.mux_channel = cfg.channel_select;
		ana_d.pos_ref     = (LOW_VOLTAGE_PART &&
			cfg.pos_ref_select == sar_adc_pkg::PREF_FVR4) ?
			sar_adc_pkg::PREF_VDD : cfg.pos_ref_select;
		ana_d.neg_ref     = cfg.neg_ref_select;
		ana_d.trial_code  = sar_d;
		ana_d.hold        = (state_d == sar_adc_pkg::ST_CONV);
	end

	// register every piece of conversion state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= sar_adc_pkg::ST_IDLE;
			half_q  <= sar_adc_pkg::HALF_TAD_ZERO;
			div_q   <= sar_adc_pkg::DIV_ZERO;
			sar_q   <= sar_adc_pkg::SAR_ZERO;
			bit_q   <= sar_adc_pkg::SAR_ZERO;
			go_q    <= 1'b0;
			flag_q  <= 1'b0;
			hi_q    <= 8'h00;
			lo_q    <= 8'h00;
			wake_q  <= 1'b0;
			vec_q   <= 1'b0;
			ana_q   <= sar_adc_pkg::ANA_RESET;
		end else begin
			state_q <= state_d;
			half_q  <= half_d;
			div_q   <= div_d;
			sar_q   <= sar_d;
			bit_q   <= bit_d;
			go_q    <= go_d;
			flag_q  <= flag_d;
			hi_q    <= hi_d;
			lo_q    <= lo_d;
			wake_q  <= wake_d;
			vec_q   <= vec_d;
			ana_q   <= ana_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign analog_ctrl      = ana_q;
	assign result_high      = hi_q;
	assign result_low       = lo_q;
	assign conv_go          = go_q;
	assign conv_done_flag   = flag_q;
	assign converter_active = state_q[1];
	assign wake_req         = wake_q;
	assign vector_isr       = vec_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] len_q, len_d; // cycles spent in the current conversion

	// next length count, cleared whenever the converter idles
	always_comb begin
		len_d = len_q + sar_adc_pkg::DIV_ONE;
		if (state_q == sar_adc_pkg::ST_IDLE) begin
			len_d = sar_adc_pkg::DIV_ZERO;
		end
	end

	// register the length count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_q <= sar_adc_pkg::DIV_ZERO;
		end else begin
			len_q <= len_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_done_quiet;
		done && !go_req;
	endsequence

	chk_go_clears: assert property (s_done_quiet |=> !conv_go)
		else $error("go still set after completion");
	chk_flag_sets: assert property (done |=> conv_done_flag)
		else $error("done flag not set at completion");
	chk_flag_sticky: assert property (
		conv_done_flag && !flag_clear |=> conv_done_flag)
		else $error("done flag dropped without software clear");
	chk_right_zero: assert property (
		done && !cfg.result_format |=> result_high[7:2] == sar_adc_pkg::FMT_PAD)
		else $error("right justified upper bits not zero");
	chk_left_zero: assert property (
		done && cfg.result_format |=> result_low[5:0] == sar_adc_pkg::FMT_PAD)
		else $error("left justified lower bits not zero");
	chk_sleep_abort: assert property (
		converter_active && sleep_mode &&
		!is_rc(cfg.conv_clock_select) |=> !converter_active)
		else $error("conversion ran on in sleep without rc clock");
	chk_conv_length: assert property (
		done && cfg.conv_clock_select == sar_adc_pkg::CCS_DIV2 &&
		$stable(cfg.conv_clock_select) |->
		len_q == {1'b0, sar_adc_pkg::HALF_TAD_LAST})
		else $error("conversion length is not 23 half periods");
	chk_wake_pulse: assert property (
		done && sleep_mode && conv_irq_enable && peripheral_irq_enable
		|=> wake_req ##1 !wake_req)
		else $error("no single wake pulse at completion in sleep");
	chk_trig_sleep: assert property (
		sleep_mode && !conv_go && !go_set |=> !conv_go)
		else $error("trigger started a conversion in sleep");

endmodule
`default_nettype wire

// ---- tb/sar_analog_model.sv ----
// Purpose: far-side model of the analog mux, hold stage and comparator
// Assumes: the held level is the bench level with the channel mixed in
// Notes:   level tracks while hold is low and freezes while hold is high
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model (
	input  wire logic                      clk,
	input  wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
	input  wire logic [9:0]                vin, // pin set analog
	output logic                           cmp_keep
);
	// ----------------------------------------------------------------
	// single sample-and-hold fed by the selected channel
	// ----------------------------------------------------------------
	logic [9:0] held_q; // level frozen for the conversion
	// tracks the routed channel until the hold closes
	always_ff @(posedge clk) begin
		if (!analog_ctrl.hold) begin
			held_q <= vin ^ {4'h0, analog_ctrl.mux_channel};
		end
	end
	// ideal comparator against the trial code
	assign cmp_keep = (held_q >= analog_ctrl.trial_code);
endmodule
`default_nettype wire

// ---- tb/sar_adc_control_tb.sv ----
// Purpose: self-checking bench of the converter control
// Assumes: 20 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   expected results follow from the bench level and the channel
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_tb;
	logic                      clk = 1'b0;
	logic                      rst_n = 1'b0;
	sar_adc_pkg::conv_cfg_t    cfg = '0;
	logic                      converter_on = 1'b0;
	logic                      go_set = 1'b0;
	logic                      flag_clear = 1'b0;
	logic                      conv_irq_enable = 1'b0;
	logic                      peripheral_irq_enable = 1'b0;
	logic                      global_irq_enable = 1'b0;
	logic                      sleep_mode = 1'b0;
	logic                      rc_clock_pin = 1'b0;
	logic                      trigger_pin = 1'b0;
	logic                      rc_run = 1'b0;  // rc oscillator running
	logic [9:0]                vin = 10'h000;  // level on the far side
	logic                      cmp_keep;
	sar_adc_pkg::analog_ctrl_t analog_ctrl;
	logic [7:0]                result_high;
	logic [7:0]                result_low;
	logic                      conv_go;
	logic                      conv_done_flag;
	logic                      converter_active;
	logic                      wake_req;
	logic                      vector_isr;
	int                        error_cnt = 0;
	int                        n_compared = 0;
	int                        n;
	// ----------------------------------------------------------------
	// clocks, design and far side
	// ----------------------------------------------------------------
	always #25 clk = ~clk;
	// rc clock with no phase relation to clk
	always #130 if (rc_run) rc_clock_pin = ~rc_clock_pin;
	sar_adc_control sar_adc_control_i (
		.clk(clk), .rst_n(rst_n), .cfg(cfg), .converter_on(converter_on),
		.go_set(go_set), .flag_clear(flag_clear),
		.conv_irq_enable(conv_irq_enable),
		.peripheral_irq_enable(peripheral_irq_enable),
		.global_irq_enable(global_irq_enable), .sleep_mode(sleep_mode),
		.rc_clock_pin(rc_clock_pin), .trigger_pin(trigger_pin),
		.cmp_keep(cmp_keep), .analog_ctrl(analog_ctrl),
		.result_high(result_high), .result_low(result_low),
		.conv_go(conv_go), .conv_done_flag(conv_done_flag),
		.converter_active(converter_active), .wake_req(wake_req),
		.vector_isr(vector_isr));
	sar_analog_model sar_analog_model_i (
		.clk(clk), .analog_ctrl(analog_ctrl), .vin(vin),
		.cmp_keep(cmp_keep));
	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// n edges, then settle
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulse_go;
		go_set = 1'b1;
		tick(1);
		go_set = 1'b0;
	endtask
	// clear flag, start, wait for the flag; n counts edges after start
	task automatic convert(input logic [2:0] ccs, input logic fmt,
			input logic [5:0] ch, input logic [9:0] v);
		logic [9:0] r;
		logic [7:0] eh;
		logic [7:0] el;
		cfg.conv_clock_select = ccs;
		cfg.result_format = fmt;
		cfg.channel_select = ch;
		vin = v;
		flag_clear = 1'b1;
		tick(1);
		flag_clear = 1'b0;
		tick(2); // acquisition wait after a channel change
		pulse_go;
		n = 1;
		while (conv_done_flag !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		r = v ^ {4'h0, ch};
		eh = fmt ? r[9:2] : {6'h00, r[9:8]};
		el = fmt ? {r[1:0], 6'h00} : r[7:0];
		chk(result_high === eh, "high");
		chk(result_low === el, "low");
		chk(conv_go === 1'b0 && converter_active === 1'b0, "go");
	endtask
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_dividers;
		logic [2:0] code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
		for (int i = 0; i < 6; i++) begin
			convert(code[i], i[0], 6'(i * 11), 10'h2a5 + 10'(i * 97));
			chk(n == 2 + 23 * (1 << i), "length");
		end
		tick(10);
		chk(conv_done_flag === 1'b1, "flag sticky");
		flag_clear = 1'b1;
		tick(1);
		flag_clear = 1'b0;
		chk(conv_done_flag === 1'b0, "flag clear");
		$display("done: dividers");
	endtask
	task automatic t_refs;
		for (int i = 0; i < 8; i++) begin
			cfg.pos_ref_select = 2'(i);
			cfg.neg_ref_select = i[2];
			cfg.channel_select = 6'(i * 9);
			tick(2);
			chk(analog_ctrl.pos_ref === 2'(i), "pos ref");
			chk(analog_ctrl.neg_ref === i[2], "neg ref");
			chk(analog_ctrl.mux_channel === 6'(i * 9), "mux");
		end
		$display("done: references");
	endtask
	task automatic t_off_and_abort;
		converter_on = 1'b0;
		pulse_go;
		tick(4);
		chk(conv_go === 1'b0, "go while off");
		converter_on = 1'b1;
		cfg.conv_clock_select = 3'h6;
		pulse_go;
		tick(40);
		sleep_mode = 1'b1;
		tick(3);
		chk({conv_go, converter_active} === 2'b00, "abort");
		pulse_go;
		tick(4);
		chk({conv_go, converter_active} === 2'b00, "go asleep");
		tick(1600);
		chk(conv_done_flag === 1'b0, "no flag");
		sleep_mode = 1'b0;
		$display("done: off and abort");
	endtask
	task automatic t_rc_sleep;
		logic [2:0] en [3] = '{3'b110, 3'b111, 3'b000};
		rc_run = 1'b1;
		sleep_mode = 1'b1;
		for (int i = 0; i < 3; i++) begin
			{conv_irq_enable, peripheral_irq_enable, global_irq_enable} = en[i];
			convert(i[0] ? 3'h7 : 3'h3, 1'b0, 6'h15, 10'h3c1);
			chk(n < 4000, "rc done");
			chk(wake_req === en[i][2], "wake");
			chk(vector_isr === (en[i][2] & en[i][0]), "vector");
			tick(1);
			chk({wake_req, vector_isr} === 2'b00, "pulse");
		end
		sleep_mode = 1'b0;
		rc_run = 1'b0;
		$display("done: rc sleep");
	endtask
	task automatic t_trigger;
		cfg.conv_clock_select = 3'h0;
		trigger_pin = 1'b1;
		n = 0;
		while (conv_go !== 1'b1 && n < 6) begin
			tick(1);
			n++;
		end
		chk(conv_go === 1'b1, "trigger");
		tick(30);
		trigger_pin = 1'b0;
		cfg.conv_clock_select = 3'h3;
		sleep_mode = 1'b1;
		tick(3);
		trigger_pin = 1'b1;
		tick(8);
		chk(conv_go === 1'b0, "trigger asleep");
		sleep_mode = 1'b0;
		trigger_pin = 1'b0;
		$display("done: trigger");
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		tick(3);
		rst_n = 1'b1;
		chk({result_high, conv_done_flag} === 9'h000, "reset");
		converter_on = 1'b1;
		t_dividers();
		t_refs();
		t_off_and_abort();
		t_rc_sleep();
		t_trigger();
		summarize();
	end
	initial begin
		#3000000;
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
